// file: verilog/ccex_core.sv
// Overview of operation
// - Sleep halts execution until wake request.
// - Word arithmetic: half carry from bit 11.
// - Extended add: zero keeps Z, else clears.
// - Decimal adjust carry sets C, else keeps.
// - Block move copies n bytes, 4n+9 cycles.
// - Unsigned divide: N follows divisor sign bit.
// - Unsigned divide: Z set when divisor zero.
`timescale 1ns/1ns
`default_nettype none
`include "ccex_defines.svh"
module ccex_core (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               startPulse,
  input  wire ccex_pkg::ccex_op_t opSel,
  input  wire logic [7:0]         immData,
  input  wire logic [15:0]        opA,
  input  wire logic [15:0]        opB,
  input  wire logic               subSel,
  input  wire logic [15:0]        spIn,
  input  wire logic [15:0]        moveSourcePtrIn,
  input  wire logic [15:0]        moveDestPtrIn,
  input  wire logic [7:0]         moveCountByteIn,
  input  wire logic               wakeReq,
  input  wire logic [15:0]        memRdata,
  output logic                    busy,
  output logic                    done,
  output logic                    sleeping,
  output logic      [7:0]         conditionCodeReg,
  output logic      [7:0]         stcData,
  output logic      [15:0]        result,
  output logic      [15:0]        pcOut,
  output logic      [15:0]        spOut,
  output logic      [15:0]        moveSourcePtr,
  output logic      [15:0]        moveDestPtr,
  output logic      [7:0]         moveCountByte,
  output logic                    memRd,
  output logic                    memWr,
  output logic                    memByte,
  output logic      [15:0]        memAddr,
  output logic      [15:0]        memWdata
);
  import ccex_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SLEEP} ccex_state_t;

  ccex_state_t state_q, state_d;
  ccex_op_t    op_q, op_d;
  logic [10:0] elap_q, elap_d, cost_q, cost_d;
  logic [15:0] a_q, a_d, b_q, b_d, sp_q, sp_d, pc_q, pc_d, res_q, res_d;
  logic [15:0] src_q, src_d, dst_q, dst_d, addr_q, addr_d, wdata_q, wdata_d;
  logic [7:0]  imm_q, imm_d, ccr_q, ccr_d, stc_q, stc_d, cnt_q, cnt_d;
  logic        sub_q, sub_d, done_q, done_d, rd_q, rd_d, wr_q, wr_d, byte_q, byte_d;
  logic        wakeMeta_q, wakeMeta_d, wakeSync_q, wakeSync_d;
  logic        busy_q, busy_d, sleep_q, sleep_d;
  logic [7:0]  flagCcr;
  logic [15:0] flagRes;
  logic [10:0] moveIdx;

  ccex_flag_calc u_flag (
    .opSel  (op_q),
    .ccrIn  (ccr_q),
    .opA    (a_q),
    .opB    (b_q),
    .subSel (sub_q),
    .ccrNew (flagCcr),
    .resNew (flagRes)
  );

  assign moveIdx = elap_q - `CCEX_MOVE_SETUP;

  always_comb begin
    state_d    = state_q;
    op_d       = op_q;
    elap_d     = elap_q;
    cost_d     = cost_q;
    a_d        = a_q;
    b_d        = b_q;
    sp_d       = sp_q;
    pc_d       = pc_q;
    res_d      = res_q;
    src_d      = src_q;
    dst_d      = dst_q;
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    imm_d      = imm_q;
    ccr_d      = ccr_q;
    stc_d      = stc_q;
    cnt_d      = cnt_q;
    sub_d      = sub_q;
    done_d     = 1'b0;
    rd_d       = 1'b0;
    wr_d       = 1'b0;
    byte_d     = byte_q;
    wakeMeta_d = wakeReq;
    wakeSync_d = wakeMeta_q;
    unique case (state_q)
      ST_IDLE: begin
        if (startPulse) begin
          state_d = ST_RUN;
          op_d    = opSel;
          elap_d  = 11'h000;
          a_d     = opA;
          b_d     = opB;
          sub_d   = subSel;
          imm_d   = immData;
          sp_d    = spIn;
          src_d   = moveSourcePtrIn;
          dst_d   = moveDestPtrIn;
          cnt_d   = moveCountByteIn;
          unique case (opSel)
            CCEX_OP_RTS:  cost_d = `CCEX_COST_RTS;
            CCEX_OP_RTE:  cost_d = `CCEX_COST_RTE;
            CCEX_OP_MOVE: cost_d = {1'b0, moveCountByteIn, 2'b00} + `CCEX_MOVE_SETUP;
            default:      cost_d = `CCEX_COST_SHORT;
          endcase
        end
      end
      ST_RUN: begin
        elap_d = elap_q + `CCEX_ELAP_ONE;
        if (elap_q == 11'h000) begin
          unique case (op_q)
            CCEX_OP_LDC:  ccr_d = imm_q;
            CCEX_OP_ANDC: ccr_d = ccr_q & imm_q;
            CCEX_OP_ORC:  ccr_d = ccr_q | imm_q;
            CCEX_OP_XORC: ccr_d = ccr_q ^ imm_q;
            CCEX_OP_STC:  stc_d = ccr_q;
            CCEX_OP_ADDW, CCEX_OP_ADDX, CCEX_OP_DAA, CCEX_OP_DIVXU: begin
              ccr_d = flagCcr;
              res_d = flagRes;
            end
            default: ;
          endcase
        end
        if (op_q == CCEX_OP_RTS || op_q == CCEX_OP_RTE) begin
          if (elap_q == `CCEX_POP_REQ0 || (op_q == CCEX_OP_RTE && elap_q == `CCEX_POP_DATA0)) begin
            rd_d   = 1'b1;
            byte_d = 1'b0;
            addr_d = (elap_q == `CCEX_POP_REQ0) ? sp_q : sp_q + `CCEX_SP_STEP;
          end
          if (elap_q == `CCEX_POP_DATA0) begin
            sp_d = sp_q + `CCEX_SP_STEP;
            if (op_q == CCEX_OP_RTE) begin
              ccr_d = memRdata[15:8];
            end else begin
              pc_d = memRdata;
            end
          end
          if (op_q == CCEX_OP_RTE && elap_q == `CCEX_POP_DATA1) begin
            pc_d = memRdata;
            sp_d = sp_q + `CCEX_SP_STEP;
          end
        end
        // Each byte is read, captured, written, then the pointers step.
        if (op_q == CCEX_OP_MOVE && elap_q >= `CCEX_MOVE_SETUP) begin
          unique case (moveIdx[1:0])
            2'h0: begin
              rd_d   = 1'b1;
              byte_d = 1'b1;
              addr_d = src_q;
            end
            2'h1: ;
            2'h2: begin
              wr_d    = 1'b1;
              byte_d  = 1'b1;
              addr_d  = dst_q;
              wdata_d = {8'h00, memRdata[7:0]};
            end
            2'h3: begin
              src_d = src_q + `CCEX_PTR_STEP;
              dst_d = dst_q + `CCEX_PTR_STEP;
              cnt_d = cnt_q - `CCEX_CNT_STEP;
            end
          endcase
        end
        if (elap_q == cost_q - `CCEX_ELAP_ONE) begin
          if (op_q == CCEX_OP_SLEEP) begin
            state_d = ST_SLEEP;
          end else begin
            state_d = ST_IDLE;
            done_d  = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (wakeSync_q) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Status outputs are decoded from the next state so they leave a flop in step with it.
    busy_d  = (state_d != ST_IDLE);
    sleep_d = (state_d == ST_SLEEP);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      op_q       <= CCEX_OP_NOP;
      elap_q     <= 11'h000;
      cost_q     <= 11'h000;
      a_q        <= 16'h0000;
      b_q        <= 16'h0000;
      sp_q       <= 16'h0000;
      pc_q       <= 16'h0000;
      res_q      <= 16'h0000;
      src_q      <= 16'h0000;
      dst_q      <= 16'h0000;
      addr_q     <= 16'h0000;
      wdata_q    <= 16'h0000;
      imm_q      <= 8'h00;
      ccr_q      <= `CCEX_CCR_RESET;
      stc_q      <= 8'h00;
      cnt_q      <= 8'h00;
      sub_q      <= 1'b0;
      done_q     <= 1'b0;
      rd_q       <= 1'b0;
      wr_q       <= 1'b0;
      byte_q     <= 1'b0;
      wakeMeta_q <= 1'b0;
      wakeSync_q <= 1'b0;
      busy_q     <= 1'b0;
      sleep_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      op_q       <= op_d;
      elap_q     <= elap_d;
      cost_q     <= cost_d;
      a_q        <= a_d;
      b_q        <= b_d;
      sp_q       <= sp_d;
      pc_q       <= pc_d;
      res_q      <= res_d;
      src_q      <= src_d;
      dst_q      <= dst_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      imm_q      <= imm_d;
      ccr_q      <= ccr_d;
      stc_q      <= stc_d;
      cnt_q      <= cnt_d;
      sub_q      <= sub_d;
      done_q     <= done_d;
      rd_q       <= rd_d;
      wr_q       <= wr_d;
      byte_q     <= byte_d;
      wakeMeta_q <= wakeMeta_d;
      wakeSync_q <= wakeSync_d;
      busy_q     <= busy_d;
      sleep_q    <= sleep_d;
    end
  end

  assign busy             = busy_q;
  assign done             = done_q;
  assign sleeping         = sleep_q;
  assign conditionCodeReg = ccr_q;
  assign stcData          = stc_q;
  assign result           = res_q;
  assign pcOut            = pc_q;
  assign spOut            = sp_q;
  assign moveSourcePtr    = src_q;
  assign moveDestPtr      = dst_q;
  assign moveCountByte    = cnt_q;
  assign memRd            = rd_q;
  assign memWr            = wr_q;
  assign memByte          = byte_q;
  assign memAddr          = addr_q;
  assign memWdata         = wdata_q;

  // Checking helpers: busy length and the count seen at start.
  logic [10:0] busyLen_q;
  logic [7:0]  nStart_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busyLen_q <= 11'h000;
      nStart_q  <= 8'h00;
    end else if (state_q == ST_IDLE) begin
      busyLen_q <= 11'h000;
      nStart_q  <= moveCountByteIn;
    end else begin
      busyLen_q <= busyLen_q + 11'h001;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sleep_hold_a: assert property (sleeping && !wakeSync_q |=> sleeping && !done)
    else $error("sleep left without wake");
  sleep_enter_a: assert property (done && op_q == CCEX_OP_SLEEP |-> $past(sleeping))
    else $error("sleep finished without sleeping");
  half_carry_a: assert property (done && op_q == CCEX_OP_ADDW && !sub_q |->
      ccr_q[`CCEX_BIT_H] == (({1'b0, a_q[11:0]} + {1'b0, b_q[11:0]}) >= 13'h1000))
    else $error("half carry wrong");
  zero_keep_a: assert property (done && op_q == CCEX_OP_ADDX |->
      ccr_q[`CCEX_BIT_Z] == ((res_q[7:0] == 8'h00) && $past(ccr_q[`CCEX_BIT_Z], 2)))
    else $error("extended zero flag wrong");
  daa_carry_a: assert property (done && op_q == CCEX_OP_DAA && $past(ccr_q[`CCEX_BIT_C], 2) |->
      ccr_q[`CCEX_BIT_C])
    else $error("decimal adjust lost carry");
  move_time_a: assert property (done && op_q == CCEX_OP_MOVE |->
      busyLen_q == {1'b0, nStart_q, 2'b00} + `CCEX_MOVE_SETUP)
    else $error("block move length wrong");
  move_end_a: assert property (done && op_q == CCEX_OP_MOVE |-> moveCountByte == 8'h00)
    else $error("block move count not zero");
  div_sign_a: assert property (done && op_q == CCEX_OP_DIVXU |-> ccr_q[`CCEX_BIT_N] == b_q[7])
    else $error("divide sign flag wrong");
  div_zero_a: assert property (done && op_q == CCEX_OP_DIVXU |->
      ccr_q[`CCEX_BIT_Z] == (b_q[7:0] == 8'h00))
    else $error("divide zero flag wrong");
  rte_stack_a: assert property (done && op_q == CCEX_OP_RTE |-> sp_q == $past(sp_q, 9) + 16'h0004)
    else $error("exception return stack wrong");
  rts_stack_a: assert property (done && op_q == CCEX_OP_RTS |-> sp_q == $past(sp_q, 7) + 16'h0002)
    else $error("subroutine return stack wrong");

  cover property (done && op_q == CCEX_OP_MOVE && nStart_q == 8'h03);
  cover property (done && op_q == CCEX_OP_RTE);
  cover property (sleeping ##1 !sleeping);
  cover property (done && op_q == CCEX_OP_DAA && ccr_q[`CCEX_BIT_C]);
endmodule // ccex_core
`default_nettype wire

// file: pkg/ccex_defines.svh
`ifndef CCEX_DEFINES_SVH
`define CCEX_DEFINES_SVH

// Condition code register bit positions.
`define CCEX_BIT_I 7
`define CCEX_BIT_H 5
`define CCEX_BIT_N 3
`define CCEX_BIT_Z 2
`define CCEX_BIT_V 1
`define CCEX_BIT_C 0
`define CCEX_CCR_RESET 8'h80

// Execution cost in core_clk cycles, one state per cycle.
`define CCEX_COST_SHORT 11'h002
`define CCEX_COST_RTS   11'h008
`define CCEX_COST_RTE   11'h00A
`define CCEX_MOVE_SETUP 11'h009

// Cycle slots of the stack pops.
`define CCEX_POP_REQ0  11'h000
`define CCEX_POP_DATA0 11'h002
`define CCEX_POP_DATA1 11'h004

`define CCEX_SP_STEP  16'h0002
`define CCEX_PTR_STEP 16'h0001
`define CCEX_CNT_STEP 8'h01
`define CCEX_ELAP_ONE 11'h001

`endif

// file: pkg/ccex_pkg.sv
package ccex_pkg;
  typedef enum logic [3:0] {
    CCEX_OP_NOP, CCEX_OP_SLEEP, CCEX_OP_LDC, CCEX_OP_STC, CCEX_OP_ANDC, CCEX_OP_ORC,
    CCEX_OP_XORC, CCEX_OP_RTS, CCEX_OP_RTE, CCEX_OP_MOVE, CCEX_OP_ADDW, CCEX_OP_ADDX,
    CCEX_OP_DAA, CCEX_OP_DIVXU
  } ccex_op_t;
endpackage

// file: verilog/ccex_flag_calc.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccex_defines.svh"
module ccex_flag_calc (
  input  wire ccex_pkg::ccex_op_t opSel,
  input  wire logic [7:0]         ccrIn,
  input  wire logic [15:0]        opA,
  input  wire logic [15:0]        opB,
  input  wire logic               subSel,
  output logic      [7:0]         ccrNew,
  output logic      [15:0]        resNew
);
  import ccex_pkg::*;
  logic [16:0] wide;
  logic [12:0] low12;
  logic [8:0]  byteRes;
  logic [7:0]  daaCorr;
  logic [8:0]  daaSum;
  always_comb begin
    ccrNew  = ccrIn;
    resNew  = opA;
    wide    = subSel ? ({1'b0, opA} - {1'b0, opB}) : ({1'b0, opA} + {1'b0, opB});
    low12   = subSel ? ({1'b0, opA[11:0]} - {1'b0, opB[11:0]}) : ({1'b0, opA[11:0]} + {1'b0, opB[11:0]});
    byteRes = subSel ? ({1'b0, opA[7:0]} - {1'b0, opB[7:0]} - {8'h00, ccrIn[`CCEX_BIT_C]})
                     : ({1'b0, opA[7:0]} + {1'b0, opB[7:0]} + {8'h00, ccrIn[`CCEX_BIT_C]});
    daaCorr = {(ccrIn[`CCEX_BIT_C] || opA[7:0] > 8'h99) ? 4'h6 : 4'h0,
               (ccrIn[`CCEX_BIT_H] || opA[3:0] > 4'h9) ? 4'h6 : 4'h0};
    daaSum  = {1'b0, opA[7:0]} + {1'b0, daaCorr};
    unique case (opSel)
      CCEX_OP_ADDW: begin
        resNew                 = wide[15:0];
        ccrNew[`CCEX_BIT_H]    = low12[12];
        ccrNew[`CCEX_BIT_C]    = wide[16];
        ccrNew[`CCEX_BIT_N]    = wide[15];
        ccrNew[`CCEX_BIT_Z]    = (wide[15:0] == 16'h0000);
        ccrNew[`CCEX_BIT_V]    = subSel ? ((opA[15] ^ opB[15]) & (opA[15] ^ wide[15]))
                                        : (~(opA[15] ^ opB[15]) & (opA[15] ^ wide[15]));
      end
      CCEX_OP_ADDX: begin
        resNew                 = {8'h00, byteRes[7:0]};
        ccrNew[`CCEX_BIT_C]    = byteRes[8];
        ccrNew[`CCEX_BIT_N]    = byteRes[7];
        if (byteRes[7:0] != 8'h00) begin
          ccrNew[`CCEX_BIT_Z]  = 1'b0;
        end
      end
      CCEX_OP_DAA: begin
        resNew                 = {8'h00, daaSum[7:0]};
        ccrNew[`CCEX_BIT_C]    = ccrIn[`CCEX_BIT_C] | daaSum[8];
        ccrNew[`CCEX_BIT_N]    = daaSum[7];
        ccrNew[`CCEX_BIT_Z]    = (daaSum[7:0] == 8'h00);
      end
      CCEX_OP_DIVXU: begin
        ccrNew[`CCEX_BIT_N]    = opB[7];
        ccrNew[`CCEX_BIT_Z]    = (opB[7:0] == 8'h00);
      end
      default: begin
        resNew = opA;
      end
    endcase
  end
endmodule // ccex_flag_calc
`default_nettype wire

// file: dv/ccex_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccex_mem_model (
  input  wire logic        core_clk,
  input  wire logic        memRd,
  input  wire logic        memWr,
  input  wire logic        memByte,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata
);
  logic [7:0] bytes [0:255];
  logic [7:0] a;
  assign a = memAddr[7:0];
  initial memRdata = 16'h0000;
  // Read data is valid for one cycle only; it toggles otherwise so that a late sample shows.
  always @(posedge core_clk) begin
    if (memRd) begin
      memRdata <= memByte ? {~bytes[a], bytes[a]} : {bytes[a], bytes[a + 8'h01]};
    end else begin
      memRdata <= ~memRdata;
    end
    if (memWr) begin
      bytes[a] <= memWdata[7:0];
    end
  end
endmodule // ccex_mem_model
`default_nettype wire

// file: dv/ccex_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ccex_core_tb_top;
  import ccex_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        startPulse = 1'b0;
  ccex_op_t    opSel = CCEX_OP_NOP;
  logic [7:0]  immData = 8'h00;
  logic [15:0] opA = 16'h0000;
  logic [15:0] opB = 16'h0000;
  logic        subSel = 1'b0;
  logic [15:0] spIn = 16'h0000;
  logic [15:0] moveSourcePtrIn = 16'h0000;
  logic [15:0] moveDestPtrIn = 16'h0000;
  logic [7:0]  moveCountByteIn = 8'h00;
  logic        wakeReq = 1'b0;
  logic [15:0] memRdata, result, pcOut, spOut, moveSourcePtr, moveDestPtr, memAddr, memWdata;
  logic [7:0]  conditionCodeReg, stcData, moveCountByte;
  logic        busy, done, sleeping, memRd, memWr, memByte;
  int          failures = 0;
  int          n_tests = 0;

  ccex_core dut (.core_clk, .rst, .startPulse, .opSel, .immData, .opA, .opB, .subSel, .spIn,
    .moveSourcePtrIn, .moveDestPtrIn, .moveCountByteIn, .wakeReq, .memRdata, .busy, .done,
    .sleeping, .conditionCodeReg, .stcData, .result, .pcOut, .spOut, .moveSourcePtr,
    .moveDestPtr, .moveCountByte, .memRd, .memWr, .memByte, .memAddr, .memWdata);
  ccex_mem_model mem (.core_clk, .memRd, .memWr, .memByte, .memAddr, .memWdata, .memRdata);

  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic go(input ccex_op_t op);
    @(posedge core_clk);
    startPulse <= 1'b1;
    opSel <= op;
    @(posedge core_clk);
    startPulse <= 1'b0;
  endtask

  // Returns the busy cycles from the taking edge to the edge that raises done.
  // Done is read at an edge before that edge updates it, so one edge is discounted.
  task automatic wt(output int n);
    n = -1;
    do begin
      @(posedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 400);
  endtask

  task automatic run(input ccex_op_t op, input int cost);
    int n;
    go(op);
    wt(n);
    chk(16'(n), 16'(cost), "cycle count");
  endtask

  task automatic t_ccr();
    ccex_op_t   op [5] = '{CCEX_OP_LDC, CCEX_OP_ANDC, CCEX_OP_ORC, CCEX_OP_XORC, CCEX_OP_NOP};
    logic [7:0] im [5] = '{8'h2A, 8'h0F, 8'hC0, 8'hFF, 8'h00};
    logic [7:0] ex [5] = '{8'h2A, 8'h0A, 8'hCA, 8'h35, 8'h35};
    chk(conditionCodeReg, 8'h80, "reset flags");
    chk(busy, 1'b0, "reset busy");
    for (int i = 0; i < 5; i++) begin
      immData <= im[i];
      run(op[i], 2);
      chk(conditionCodeReg, ex[i], "flag op");
    end
    run(CCEX_OP_STC, 2);
    chk(stcData, 8'h35, "flag store");
  endtask

  task automatic t_ret();
    mem.bytes[8'h40] = 8'hA5;
    mem.bytes[8'h41] = 8'h00;
    mem.bytes[8'h42] = 8'h12;
    mem.bytes[8'h43] = 8'h34;
    mem.bytes[8'h50] = 8'hBE;
    mem.bytes[8'h51] = 8'hEF;
    spIn <= 16'h0040;
    run(CCEX_OP_RTE, 10);
    chk(conditionCodeReg, 8'hA5, "popped flags");
    chk(pcOut, 16'h1234, "popped pc");
    chk(spOut, 16'h0044, "stack after two pops");
    spIn <= 16'h0050;
    run(CCEX_OP_RTS, 8);
    chk(pcOut, 16'hBEEF, "return pc");
    chk(spOut, 16'h0052, "stack after one pop");
    chk(conditionCodeReg, 8'hA5, "flags kept on return");
  endtask

  task automatic ar(input ccex_op_t op, input logic [7:0] pre, input logic [15:0] a, input logic [15:0] b,
                    input logic sub, input logic [7:0] msk, input logic [7:0] ecc, input logic [15:0] eres);
    immData <= pre;
    run(CCEX_OP_LDC, 2);
    opA <= a;
    opB <= b;
    subSel <= sub;
    run(op, 2);
    chk(conditionCodeReg & msk, ecc, "flags");
    if (op != CCEX_OP_DIVXU) begin
      chk(result, eres, "result");
    end
  endtask

  task automatic t_arith();
    ar(CCEX_OP_ADDW, 8'h00, 16'h0800, 16'h0800, 1'b0, 8'hFF, 8'h20, 16'h1000);
    ar(CCEX_OP_ADDW, 8'h00, 16'h0700, 16'h0100, 1'b0, 8'hFF, 8'h00, 16'h0800);
    ar(CCEX_OP_ADDW, 8'h00, 16'h1000, 16'h0001, 1'b1, 8'hFF, 8'h20, 16'h0FFF);
    ar(CCEX_OP_ADDX, 8'h04, 16'h0000, 16'h0000, 1'b0, 8'hFF, 8'h04, 16'h0000);
    ar(CCEX_OP_ADDX, 8'h00, 16'h0000, 16'h0000, 1'b0, 8'hFF, 8'h00, 16'h0000);
    ar(CCEX_OP_ADDX, 8'h04, 16'h0001, 16'h0001, 1'b0, 8'hFF, 8'h00, 16'h0002);
    ar(CCEX_OP_ADDX, 8'h04, 16'h0005, 16'h0005, 1'b1, 8'hFF, 8'h04, 16'h0000);
    ar(CCEX_OP_DAA, 8'h01, 16'h0000, 16'h0000, 1'b0, 8'h01, 8'h01, 16'h0060);
    ar(CCEX_OP_DAA, 8'h00, 16'h009A, 16'h0000, 1'b0, 8'h01, 8'h01, 16'h0000);
    ar(CCEX_OP_DAA, 8'h00, 16'h0012, 16'h0000, 1'b0, 8'h01, 8'h00, 16'h0012);
    ar(CCEX_OP_DIVXU, 8'h00, 16'h0000, 16'h0080, 1'b0, 8'h0C, 8'h08, 16'h0000);
    ar(CCEX_OP_DIVXU, 8'h00, 16'h0000, 16'h0000, 1'b0, 8'h0C, 8'h04, 16'h0000);
    ar(CCEX_OP_DIVXU, 8'h0C, 16'h0000, 16'h007F, 1'b0, 8'h0C, 8'h00, 16'h0000);
  endtask

  task automatic t_move();
    for (int i = 0; i < 3; i++) begin
      mem.bytes[8'h10 + i] = 8'h11 * (i + 1);
    end
    mem.bytes[8'h90] = 8'h5A;
    moveSourcePtrIn <= 16'h0010;
    moveDestPtrIn <= 16'h0080;
    moveCountByteIn <= 8'h03;
    run(CCEX_OP_MOVE, 21);
    for (int i = 0; i < 3; i++) begin
      chk(mem.bytes[8'h80 + i], 8'h11 * (i + 1), "moved byte");
    end
    chk(moveSourcePtr, 16'h0013, "source end");
    chk(moveDestPtr, 16'h0083, "dest end");
    chk(moveCountByte, 8'h00, "count end");
    moveSourcePtrIn <= 16'h0020;
    moveDestPtrIn <= 16'h0090;
    moveCountByteIn <= 8'h00;
    run(CCEX_OP_MOVE, 9);
    chk(mem.bytes[8'h90], 8'h5A, "empty move writes nothing");
    chk(moveSourcePtr, 16'h0020, "empty move source");
  endtask

  task automatic t_sleep();
    int n;
    logic early = 1'b0;
    go(CCEX_OP_SLEEP);
    repeat (20) begin
      @(posedge core_clk);
      early = early | (done !== 1'b0);
    end
    chk(early, 1'b0, "no done while asleep");
    chk(sleeping, 1'b1, "asleep");
    chk(busy, 1'b1, "busy while asleep");
    wakeReq <= 1'b1;
    wt(n);
    chk(16'(n >= 2 && n <= 6), 16'h0001, "wake delay");
    wakeReq <= 1'b0;
    @(posedge core_clk);
    chk(sleeping, 1'b0, "awake");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_ccr();
    t_ret();
    t_arith();
    t_move();
    t_sleep();
    final_report();
  end

  initial begin
    #200000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // ccex_core_tb_top
`default_nettype wire
